// file: hw/tws_port.sv
/*
  Two-wire / SMBus slave register port of a temperature monitor: START/STOP
  and bit recovery by oversampling, pointer and register file, MSB-first
  reads, bus timeout, high-speed mode tracking, software reset and the
  alert-response answer. Assumes SCL and SDA pins are asynchronous and the
  pad logic forms the open-drain wire from sda_oe (high while pulling low).
*/
// Overview of operation
// - Transaction starts with seven address bits then direction bit, low means write.
// - Slave answers to 1001100b or 1001101b, fixed by build variant.
// - First written byte loads pointer; later bytes write the selected register.
// - Reads use the last written pointer; it persists across reads.
// - Two-byte reads send the selected register byte twice; the pointer does not advance.
// - Bus timeout only works while timeout-enable bit 7 is set.
// - Line low 30 ms inside a frame resets the port and frees lines.
// - Timeout-enable bit resets to one.
// - High-speed master code 00001XXX is not acknowledged; filters go high-speed.
// - High-speed mode lasts until a STOP, then normal filters return.
// - General call 00h with second byte 06h does software reset.
// - Software reset restores registers, aborts conversion, clears alert and thermal out.
// - A data byte written with pointer FCh triggers the same software reset.
// - While alert is asserted, acknowledge 00011001 and return own address.
// - Returned eighth bit high for over-limit, low for under-limit cause.
// - Lost arbitration keeps alert; won arbitration drops alert at the end.
// - Pointer resets to 00h.
// - Writing the one-shot location starts one conversion, stores nothing.
module tws_port #(
  parameter logic        VARIANT_B      = 1'b0,
  parameter int unsigned TIMEOUT_CYCLES = tws_pkg::TIMEOUT_CYCLES
) (
  input  wire logic       mclk,
  input  wire logic       srst,
  input  wire logic       ce,
  input  wire logic       scl_in,
  input  wire logic       sda_in,
  output logic            sda_out,
  output logic            sda_oe,
  input  wire logic [7:0] local_temp,
  input  wire logic [7:0] remote_temp,
  input  wire logic [7:0] event_status,
  input  wire logic       alert_raise,
  input  wire logic       thermal_raise,
  output logic            alert_out,
  output logic            thermal_limit_out,
  output logic            conv_start,
  output logic            conv_abort,
  output logic            hs_mode,
  output logic [7:0]      device_setup,
  output logic [7:0]      sample_rate_select,
  output logic [7:0]      local_upper_limit_high,
  output logic [7:0]      local_lower_limit_high,
  output logic [7:0]      remote_upper_limit_high,
  output logic [7:0]      remote_lower_limit_high,
  output logic [7:0]      consec_alert
);

  typedef enum logic [2:0] {
    TWS_IDLE, TWS_RX, TWS_ACK, TWS_TX, TWS_TXACK
  } tws_state_e;

  localparam logic [6:0] OWN_ADDR = VARIANT_B ? tws_pkg::ADDR_VARIANT_B
                                              : tws_pkg::ADDR_VARIANT_A;

  tws_state_e  st_q;
  logic        scl_s, sda_s, scl_p_q, sda_p_q;
  logic [7:0]  shift_q;
  logic [3:0]  bit_q;
  logic [1:0]  byte_q;        // 0 address, 1 first data, 2 later
  logic        sel_q, rd_q, gc_q, ara_q, ara_lost_q, ack_q, busy_q, sw_rst_q;
  logic [7:0]  ptr_q;
  logic        tmo;

  // Pin synchronisers and low-time watchdog
  tws_sync #(.INIT(1'b1)) u_scl (.mclk(mclk), .srst(srst), .ce(ce), .pin(scl_in),
                                  .level(scl_s));
  tws_sync #(.INIT(1'b1)) u_sda (.mclk(mclk), .srst(srst), .ce(ce), .pin(sda_in),
                                  .level(sda_s));
  tws_lowtimer #(.LIMIT(TIMEOUT_CYCLES)) u_tmo (
    .mclk   (mclk),
    .srst   (srst),
    .ce     (ce),
    .run    (busy_q && consec_alert[tws_pkg::BIT_TIMEOUT_EN] && (!scl_s || !sda_s)),
    .expire (tmo)
  );

  // Bus condition decode
  wire scl_rise  = scl_s && !scl_p_q;
  wire scl_fall  = !scl_s && scl_p_q;
  wire start_det = scl_s && scl_p_q && sda_p_q && !sda_s;
  wire stop_det  = scl_s && scl_p_q && !sda_p_q && sda_s;
  wire [7:0] rx_byte = shift_q;
  wire addr_me   = rx_byte[7:1] == OWN_ADDR;
  wire addr_gc   = rx_byte[7:1] == tws_pkg::ADDR_GEN_CALL && !rx_byte[0];
  wire addr_ara  = rx_byte == tws_pkg::ADDR_ALERT_RESP && alert_out;
  wire addr_hs   = rx_byte[7:3] == tws_pkg::HS_CODE_TOP;
  // Alert answer: own address plus cause bit (high for over-limit)
  wire [7:0] ara_byte = {OWN_ADDR, thermal_raise | event_status[6] | event_status[4]};

  // Read mux, unmapped locations read zero
  wire [7:0] rd_data =
    (ptr_q == tws_pkg::PTR_LOCAL_TEMP)  ? local_temp :
    (ptr_q == tws_pkg::PTR_REMOTE_TEMP) ? remote_temp :
    (ptr_q == tws_pkg::PTR_EVENT_FLAGS) ? event_status :
    (ptr_q == tws_pkg::PTR_SETUP_RD)    ? device_setup :
    (ptr_q == tws_pkg::PTR_RATE_RD)     ? sample_rate_select :
    (ptr_q == tws_pkg::PTR_LUL_RD)      ? local_upper_limit_high :
    (ptr_q == tws_pkg::PTR_LLL_RD)      ? local_lower_limit_high :
    (ptr_q == tws_pkg::PTR_RUL_RD)      ? remote_upper_limit_high :
    (ptr_q == tws_pkg::PTR_RLL_RD)      ? remote_lower_limit_high :
    (ptr_q == tws_pkg::PTR_CONSEC)      ? consec_alert : 8'h00;

  // A completed data byte in a write to this slave
  wire wr_byte   = (st_q == TWS_RX) && scl_fall && bit_q == 4'h8 && sel_q && !rd_q
                   && !gc_q && byte_q != 2'h0;
  wire wr_ptr    = wr_byte && byte_q == 2'h1;
  wire wr_data   = wr_byte && byte_q == 2'h2;
  wire gc_reset  = (st_q == TWS_RX) && scl_fall && bit_q == 4'h8 && gc_q
                   && byte_q == 2'h1 && rx_byte == tws_pkg::GEN_CALL_RESET;
  wire soft_rst  = gc_reset || (wr_data && ptr_q == tws_pkg::PTR_SOFT_RESET);
  wire reg_rst   = srst || (ce && sw_rst_q);                               // Frozen while ce is low

  // Line history for edge finding
  always_ff @(posedge mclk) begin
    if (srst) begin
      scl_p_q <= 1'b1;
      sda_p_q <= 1'b1;
    end else if (ce) begin
      scl_p_q <= scl_s;
      sda_p_q <= sda_s;
    end
  end

  // Frame tracking and high-speed mode
  always_ff @(posedge mclk) begin
    if (srst) begin
      busy_q  <= 1'b0;
      hs_mode <= 1'b0;
    end else if (ce) begin
      if (start_det) busy_q <= 1'b1;
      else if (stop_det || tmo) busy_q <= 1'b0;
      if (stop_det) hs_mode <= 1'b0;
      else if ((st_q == TWS_RX) && scl_fall && bit_q == 4'h8 && byte_q == 2'h0
               && addr_hs) hs_mode <= 1'b1;
    end
  end

  // Bit engine: shift on SCL rise, drive SDA after SCL fall
  always_ff @(posedge mclk) begin
    if (srst || (ce && tmo)) begin
      st_q <= TWS_IDLE;
      shift_q <= 8'h00; bit_q <= 4'h0; byte_q <= 2'h0;
      sel_q <= 1'b0; rd_q <= 1'b0; gc_q <= 1'b0; ara_q <= 1'b0;
      ara_lost_q <= 1'b0; ack_q <= 1'b0;
      sda_out <= 1'b0; sda_oe <= 1'b0;
    end else if (ce) begin
      if (start_det) begin
        st_q <= TWS_RX; bit_q <= 4'h0; byte_q <= 2'h0;
        ara_lost_q <= 1'b0;                                                // Fresh arbitration per command
        sel_q <= 1'b0; rd_q <= 1'b0; gc_q <= 1'b0; ara_q <= 1'b0;
        sda_oe <= 1'b0;
      end else if (stop_det) begin
        st_q <= TWS_IDLE; sda_oe <= 1'b0;
      end else begin
        unique case (st_q)
          TWS_IDLE: ;
          TWS_RX: begin
            // Bits counted on rises: the SCL fall closing a START carries no bit
            if (scl_rise) begin
              shift_q <= {shift_q[6:0], sda_s};
              bit_q   <= bit_q + 4'h1;
            end
            if (scl_fall) begin
              if (bit_q == 4'h8) begin
                bit_q <= 4'h0;
                st_q  <= TWS_ACK;
                ack_q <= 1'b0;
                if (byte_q == 2'h0) begin
                  // Address byte: decide who answers
                  sel_q <= addr_me || addr_gc || addr_ara;
                  rd_q  <= rx_byte[0];
                  gc_q  <= addr_gc;
                  ara_q <= addr_ara;
                  ack_q <= addr_me || addr_gc || addr_ara;
                  byte_q <= 2'h1;
                end else begin
                  ack_q  <= sel_q && !(gc_q && byte_q == 2'h2);
                  byte_q <= 2'h2;
                end
                sda_oe <= addr_me || addr_gc || addr_ara || (byte_q != 2'h0 && sel_q);
              end
            end
          end
          TWS_ACK: begin
            // Ack pulled low during the ninth clock, then released, or for a read the first data bit driven
            if (!ack_q) sda_oe <= 1'b0;
            if (scl_fall) begin
              if (!sel_q) begin
                st_q <= TWS_IDLE; sda_oe <= 1'b0;
              end else if (rd_q) begin
                st_q    <= TWS_TX;
                shift_q <= ara_q ? ara_byte : rd_data;
                sda_oe  <= ara_q ? ~ara_byte[7] : ~rd_data[7];
              end else begin
                st_q <= TWS_RX; sda_oe <= 1'b0;
              end
            end
          end
          TWS_TX: begin
            // Lost arbitration: line low while we left it released
            if (scl_rise && !sda_oe && !sda_s) begin
              st_q <= TWS_IDLE; ara_lost_q <= ara_q;
            end else if (scl_fall) begin
              if (bit_q == 4'h7) begin
                bit_q <= 4'h0; st_q <= TWS_TXACK; sda_oe <= 1'b0;
              end else begin
                bit_q   <= bit_q + 4'h1;
                shift_q <= {shift_q[6:0], 1'b0};
                sda_oe  <= ~shift_q[6];
              end
            end
          end
          TWS_TXACK: begin
            if (scl_rise) ack_q <= !sda_s;
            if (scl_fall) begin
              if (ack_q && !ara_q) begin
                st_q    <= TWS_TX;
                shift_q <= rd_data;
                sda_oe  <= ~rd_data[7];
              end else begin
                st_q <= TWS_IDLE;
              end
            end
          end
          default: st_q <= TWS_IDLE;
        endcase
      end
    end
  end

  // Pointer, register file and control pulses
  always_ff @(posedge mclk) begin
    if (reg_rst) begin
      ptr_q                   <= tws_pkg::RST_PTR;
      device_setup            <= tws_pkg::RST_SETUP;
      sample_rate_select      <= tws_pkg::RST_RATE;
      local_upper_limit_high  <= tws_pkg::RST_UPPER;
      local_lower_limit_high  <= tws_pkg::RST_LOWER;
      remote_upper_limit_high <= tws_pkg::RST_UPPER;
      remote_lower_limit_high <= tws_pkg::RST_LOWER;
      consec_alert            <= tws_pkg::RST_CONSEC;
      conv_start              <= 1'b0;
      conv_abort              <= sw_rst_q;
      sw_rst_q                <= 1'b0;
    end else if (ce) begin
      conv_start <= 1'b0;
      conv_abort <= 1'b0;
      sw_rst_q   <= soft_rst;
      if (wr_ptr) ptr_q <= rx_byte;
      if (wr_data) begin
        unique case (ptr_q)
          tws_pkg::PTR_SETUP_WR: device_setup <= rx_byte & tws_pkg::SETUP_MASK;
          tws_pkg::PTR_RATE_WR:  sample_rate_select <= rx_byte & tws_pkg::RATE_MASK;
          tws_pkg::PTR_LUL_WR:   local_upper_limit_high <= rx_byte;
          tws_pkg::PTR_LLL_WR:   local_lower_limit_high <= rx_byte;
          tws_pkg::PTR_RUL_WR:   remote_upper_limit_high <= rx_byte;
          tws_pkg::PTR_RLL_WR:   remote_lower_limit_high <= rx_byte;
          tws_pkg::PTR_CONSEC:   consec_alert <= rx_byte & tws_pkg::CONSEC_MASK;
          tws_pkg::PTR_ONE_SHOT: conv_start <= 1'b1;
          default: ;
        endcase
      end
    end
  end

  // Alert and thermal outputs; a raise wins over the arbitration clear
  always_ff @(posedge mclk) begin
    if (reg_rst) begin
      alert_out         <= 1'b0;
      thermal_limit_out <= 1'b0;
    end else if (ce) begin
      thermal_limit_out <= thermal_raise;
      if (alert_raise) alert_out <= 1'b1;
      else if (stop_det && ara_q && !ara_lost_q && st_q != TWS_RX) alert_out <= 1'b0;
    end
  end

endmodule

// file: hw/tws_pkg.sv
/*
  Package for the two-wire slave register port: register pointer values,
  reset values, field positions, bus addresses and timing counts.
  Assumes a 25 MHz system clock; used by tws_port, not by the synchroniser or low-time watchdog.
*/
package tws_pkg;

  // System clock and bus low-time timeout
  localparam int unsigned CLK_HZ          = 25000000;
  localparam int unsigned TIMEOUT_MS      = 30;
  localparam int unsigned TIMEOUT_CYCLES  = CLK_HZ / 1000 * TIMEOUT_MS;

  // Slave addresses (seven bits), alert-response byte, high-speed code top and general-call reset byte
  localparam logic [6:0] ADDR_VARIANT_A   = 7'h4C;
  localparam logic [6:0] ADDR_VARIANT_B   = 7'h4D;
  localparam logic [6:0] ADDR_GEN_CALL    = 7'h00;
  localparam logic [7:0] ADDR_ALERT_RESP  = 8'h19;
  localparam logic [4:0] HS_CODE_TOP      = 5'h01;
  localparam logic [7:0] GEN_CALL_RESET   = 8'h06;

  // Read pointer values
  localparam logic [7:0] PTR_LOCAL_TEMP   = 8'h00;
  localparam logic [7:0] PTR_REMOTE_TEMP  = 8'h01;
  localparam logic [7:0] PTR_EVENT_FLAGS  = 8'h02;
  localparam logic [7:0] PTR_SETUP_RD     = 8'h03;
  localparam logic [7:0] PTR_RATE_RD      = 8'h04;
  localparam logic [7:0] PTR_LUL_RD       = 8'h05;
  localparam logic [7:0] PTR_LLL_RD       = 8'h06;
  localparam logic [7:0] PTR_RUL_RD       = 8'h07;
  localparam logic [7:0] PTR_RLL_RD       = 8'h08;
  localparam logic [7:0] PTR_CONSEC       = 8'h22;
  // Write pointer values
  localparam logic [7:0] PTR_SETUP_WR     = 8'h09;
  localparam logic [7:0] PTR_RATE_WR      = 8'h0A;
  localparam logic [7:0] PTR_LUL_WR       = 8'h0B;
  localparam logic [7:0] PTR_LLL_WR       = 8'h0C;
  localparam logic [7:0] PTR_RUL_WR       = 8'h0D;
  localparam logic [7:0] PTR_RLL_WR       = 8'h0E;
  localparam logic [7:0] PTR_ONE_SHOT     = 8'h0F;
  localparam logic [7:0] PTR_SOFT_RESET   = 8'hFC;

  // Reset values
  localparam logic [7:0] RST_PTR          = 8'h00;
  localparam logic [7:0] RST_SETUP        = 8'h00;
  localparam logic [7:0] RST_RATE         = 8'h08;
  localparam logic [7:0] RST_UPPER        = 8'h55;
  localparam logic [7:0] RST_LOWER        = 8'h00;
  localparam logic [7:0] RST_CONSEC       = 8'h81;

  // Field positions
  localparam int unsigned BIT_TIMEOUT_EN  = 7;
  localparam int unsigned BIT_ALERT_MASK  = 7;
  localparam int unsigned BIT_STANDBY     = 6;
  localparam int unsigned BIT_PIN6_FUNC   = 5;
  localparam logic [7:0]  RATE_MASK       = 8'h0F;
  localparam logic [7:0]  SETUP_MASK      = 8'hE4;
  localparam logic [7:0]  CONSEC_MASK     = 8'h8E;

endpackage

// file: hw/tws_sync.sv
/*
  Two-flop synchroniser for one pin level.
  Assumes the input is asynchronous to mclk; output is registered.
*/
module tws_sync #(
  parameter logic INIT = 1'b1
) (
  input  wire logic mclk,
  input  wire logic srst,
  input  wire logic ce,
  input  wire logic pin,
  output logic      level
);

  logic meta_q;

  // First flop feeds only the second
  always_ff @(posedge mclk) begin
    if (srst) begin
      meta_q <= INIT;
      level  <= INIT;
    end else if (ce) begin
      meta_q <= pin;
      level  <= meta_q;
    end
  end

endmodule

// file: hw/tws_lowtimer.sv
/*
  Low-time watchdog: counts cycles while a line is low inside a frame.
  Assumes synchronised inputs on mclk; expire is a one-cycle pulse.
*/
module tws_lowtimer #(
  parameter int unsigned LIMIT = 750000
) (
  input  wire logic mclk,
  input  wire logic srst,
  input  wire logic ce,
  input  wire logic run,
  output logic      expire
);

  logic [19:0] cnt_q;

  // Restart whenever the line is released or the frame ends
  always_ff @(posedge mclk) begin
    if (srst) begin
      cnt_q  <= 20'h00000;
      expire <= 1'b0;
    end else if (ce) begin
      expire <= 1'b0;
      if (!run) begin
        cnt_q <= 20'h00000;
      end else if (cnt_q == 20'(LIMIT - 1)) begin
        cnt_q  <= 20'h00000;
        expire <= 1'b1;
      end else begin
        cnt_q <= cnt_q + 20'h00001;
      end
    end
  end

endmodule

// file: tb/tws_port_monitor.sv
/*
  Checker for the two-wire slave port: timing and reset relations at its ports.
  Assumes it is bound to tws_port and that the pins it sees are resolved levels.
*/
module tws_port_monitor #(
  parameter int unsigned TIMEOUT_CYCLES = 2000
) (
  input wire logic       mclk,
  input wire logic       srst,
  input wire logic       scl_in,
  input wire logic       sda_in,
  input wire logic       sda_oe,
  input wire logic       alert_raise,
  input wire logic       alert_out,
  input wire logic       conv_start,
  input wire logic       conv_abort,
  input wire logic       hs_mode,
  input wire logic [7:0] device_setup,
  input wire logic [7:0] sample_rate_select,
  input wire logic [7:0] local_upper_limit_high,
  input wire logic [7:0] consec_alert
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking @(posedge mclk); endclocking
  default disable iff (srst);

  logic [4:0]  evt_age_q;
  logic [31:0] low_cnt_q;

  // Age since the last STOP or abort; saturates so it never wraps
  always_ff @(posedge mclk) begin
    if (srst || conv_abort || (scl_in && $rose(sda_in))) evt_age_q <= 5'h00;
    else if (evt_age_q != 5'h1F) evt_age_q <= evt_age_q + 5'h01;
  end

  // Cycles with a line held low while the timeout is armed
  always_ff @(posedge mclk) begin
    if (srst || (scl_in && sda_in) || !consec_alert[7]) low_cnt_q <= 32'h0;
    else low_cnt_q <= low_cnt_q + 32'h1;
  end

  a_reset_values: assert property (
    $fell(srst) |-> sample_rate_select == 8'h08 && device_setup == 8'h00
      && local_upper_limit_high == 8'h55 && consec_alert == 8'h81)
    else $error("register not at reset value after reset");
  a_start_pulse: assert property (conv_start |=> !conv_start)
    else $error("conversion start longer than one cycle");
  a_abort_pulse: assert property (conv_abort |=> !conv_abort)
    else $error("conversion abort longer than one cycle");
  a_abort_restores: assert property (
    $rose(conv_abort) |-> ##[0:2] (sample_rate_select == 8'h08
      && consec_alert == 8'h81 && device_setup == 8'h00))
    else $error("soft reset left registers changed");
  a_hs_until_stop: assert property ($fell(hs_mode) |-> evt_age_q < 5'd10)
    else $error("high-speed mode ended without STOP");
  a_oe_scl_low: assert property ($changed(sda_oe) |-> !$past(scl_in, 2))
    else $error("data line drive changed while clock high");
  a_timeout_free: assert property (low_cnt_q > TIMEOUT_CYCLES + 16 |-> !sda_oe)
    else $error("data line still driven after bus timeout");
  a_alert_set: assert property (alert_raise |=> alert_out)
    else $error("alert output not raised");
  a_alert_clear: assert property ($fell(alert_out) |-> ##[0:2] (evt_age_q < 5'd10))
    else $error("alert dropped outside STOP or reset");

  // Main scenarios reached
  c_hs: cover property ($rose(hs_mode));
  c_start: cover property (conv_start);
  c_alert_clear: cover property ($fell(alert_out));
endmodule

bind tws_port tws_port_monitor #(.TIMEOUT_CYCLES(TIMEOUT_CYCLES)) u_mon (
  .mclk(mclk), .srst(srst), .scl_in(scl_in), .sda_in(sda_in), .sda_oe(sda_oe),
  .alert_raise(alert_raise), .alert_out(alert_out), .conv_start(conv_start),
  .conv_abort(conv_abort), .hs_mode(hs_mode), .device_setup(device_setup),
  .sample_rate_select(sample_rate_select),
  .local_upper_limit_high(local_upper_limit_high), .consec_alert(consec_alert));

// file: tb/tws_bus_master.sv
/*
  Behavioural two-wire bus master: START, STOP, bits and bytes on SCL and SDA.
  Assumes the bench resolves the open-drain SDA wire with a pull-up.
*/
module tws_bus_master (
  input  wire logic mclk,
  input  wire logic sda,
  output logic      scl,
  output logic      sda_rel
);
  timeunit 1ns;
  timeprecision 100ps;

  // Bus idle: both lines released
  initial begin
    scl = 1'b1;
    sda_rel = 1'b1;
  end

  // Half a bit: four system clocks, 320 ns per bit, far above the minimum rate
  task automatic hp();
    repeat (4) @(posedge mclk);
    #1;
  endtask

  // Also serves as repeated START from a low clock
  task automatic start();
    sda_rel = 1'b1;
    hp();
    scl = 1'b1;
    hp();
    sda_rel = 1'b0;
    hp();
    scl = 0;
    hp();
  endtask

  task automatic stop();
    sda_rel = 1'b0;
    hp();
    scl = 1'b1;
    hp();
    sda_rel = 1'b1;
    hp();
  endtask

  // Data changes only while the clock is low; sampled at end of high time
  task automatic send_bit(input logic b, output logic r);
    sda_rel = b;
    hp();
    scl = 1'b1;
    hp();
    r = sda;
    scl = 1'b0;
  endtask

  // Seven address bits then direction, or a data byte; MSB first
  task automatic wbyte(input logic [7:0] b, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) send_bit(b[i], r);
    send_bit(1'b1, r);
    ack = !r;
  endtask

  // Last byte of a read is refused with a high acknowledge slot
  task automatic rbyte(input logic last, output logic [7:0] b);
    logic r;
    for (int i = 7; i >= 0; i--) send_bit(1'b1, b[i]);
    send_bit(last, r);
  endtask
endmodule

// file: tb/twowire_slave_register_port_test.sv
/*
  Self-checking bench for the two-wire slave port, driving it through a bus master.
  Assumes a 25 MHz clock and a shortened bus timeout parameter.
*/
`define CHECK_EQ(nm, e, g) begin tests_run++; if ((g) !== (e)) begin bad_count++; \
  $display("MISMATCH %s expected %0h seen %0h", nm, e, g); end end
module twowire_slave_register_port_test;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int unsigned TO_CYC = 2000;
  logic       mclk, srst, alert_raise, thermal_raise, ack, r;
  logic [7:0] local_temp, remote_temp, event_status, rd;
  logic [7:0] adr = 8'h98;
  wire logic  scl, sda_rel, sda_oe, alert_out, thermal_limit_out, conv_start, conv_abort, hs_mode;
  wire logic [7:0] device_setup, sample_rate_select, lul, lll, rul, rll, consec_alert;
  wire logic  sda = sda_rel & ~sda_oe; // Open-drain wire with pull-up
  int         bad_count, tests_run, starts, aborts;
  logic [7:0] rp[8] = '{8'h00, 8'h01, 8'h02, 8'h03, 8'h05, 8'h07, 8'h22, 8'h40};
  logic [7:0] rv[8] = '{8'h3A, 8'h5C, 8'h20, 8'h00, 8'h55, 8'h55, 8'h81, 8'h00};
  logic [7:0] wp[6] = '{8'h09, 8'h0A, 8'h0B, 8'h0C, 8'h0D, 8'h0E};
  logic [7:0] wd[6] = '{8'hFF, 8'h05, 8'h66, 8'h11, 8'h77, 8'h22};
  logic [7:0] ev[6] = '{8'hE4, 8'h05, 8'h66, 8'h11, 8'h77, 8'h22};

  tws_port #(.VARIANT_B(1'b0), .TIMEOUT_CYCLES(TO_CYC)) uut (
    .mclk(mclk), .srst(srst), .ce(1'b1), .scl_in(scl), .sda_in(sda), .sda_out(),
    .sda_oe(sda_oe), .local_temp(local_temp), .remote_temp(remote_temp),
    .event_status(event_status), .alert_raise(alert_raise), .thermal_raise(thermal_raise),
    .alert_out(alert_out), .thermal_limit_out(thermal_limit_out), .conv_start(conv_start),
    .conv_abort(conv_abort), .hs_mode(hs_mode), .device_setup(device_setup),
    .sample_rate_select(sample_rate_select), .local_upper_limit_high(lul),
    .local_lower_limit_high(lll), .remote_upper_limit_high(rul),
    .remote_lower_limit_high(rll), .consec_alert(consec_alert));
  tws_bus_master m (.mclk(mclk), .sda(sda), .scl(scl), .sda_rel(sda_rel));

  initial begin
    mclk = 1'b0;
    forever #20 mclk = ~mclk;
  end

  // Count conversion pulses; each is only one cycle wide
  always @(posedge mclk) begin
    if (conv_start === 1'b1) starts++;
    if (conv_abort === 1'b1) aborts++;
  end

  task automatic cyc(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask

  task automatic wr(input logic [7:0] p, input logic [7:0] d, input logic has_d);
    m.start();
    m.wbyte(8'h98, ack);
    m.wbyte(p, ack);
    if (has_d) m.wbyte(d, ack);
    m.stop();
  endtask

  // Pointer write, repeated START, single-byte read
  task automatic rdr(input logic [7:0] p, input logic [7:0] e);
    m.start();
    m.wbyte(8'h98, ack);
    m.wbyte(p, ack);
    m.start();
    m.wbyte(8'h99, ack);
    m.rbyte(1'b1, rd);
    m.stop();
    `CHECK_EQ("read data", e, rd)
  endtask

  task automatic gc(input logic [7:0] b);
    m.start();
    m.wbyte(8'h00, ack);
    m.wbyte(b, ack);
    m.stop();
    `CHECK_EQ("general call ack", 1'b1, ack)
  endtask

  task automatic complete_run();
    if (bad_count == 0 && tests_run > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // Watchdog sized well above the whole sequence
  initial begin
    repeat (60000) @(posedge mclk);
    bad_count++;
    complete_run();
  end

  initial begin
    srst = 1'b1;
    alert_raise = 1'b0;
    thermal_raise = 1'b0;
    local_temp = 8'h3A;
    remote_temp = 8'h5C;
    event_status = 8'h20;
    cyc(5);
    srst = 1'b0;
    cyc(3);
    `CHECK_EQ("consec", 8'h81, consec_alert)
    m.start();
    m.wbyte(8'h99, ack);
    m.rbyte(1'b1, rd);
    m.stop();
    `CHECK_EQ("first read", 8'h3A, rd)
    for (int i = 0; i < 8; i++) rdr(rp[i], rv[i]);
    for (int i = 0; i < 6; i++) begin
      wr(wp[i], wd[i], 1'b1);
      rdr(wp[i] - 8'h06, ev[i]);
    end
    `CHECK_EQ("limit regs", 32'h66117722, {lul, lll, rul, rll})
    wr(8'h01, 8'hFF, 1'b1);
    rdr(8'h01, 8'h5C);
    rdr(8'h04, 8'h05);
    m.start();
    m.wbyte(8'h99, ack);
    m.rbyte(1'b0, rd);
    `CHECK_EQ("first byte", 8'h05, rd)
    m.rbyte(1'b1, rd);
    m.stop();
    `CHECK_EQ("second byte", 8'h05, rd)
    m.start();
    m.wbyte(8'h9A, ack);
    m.stop();
    `CHECK_EQ("other address ack", 1'b0, ack)
    wr(8'h0F, 8'h5A, 1'b1);
    `CHECK_EQ("conv starts", 1, starts)
    rdr(8'h04, 8'h05);
    wr(8'hFC, 8'h00, 1'b1);
    cyc(4);
    `CHECK_EQ("aborts", 1, aborts)
    rdr(8'h04, 8'h08);
    wr(8'h0A, 8'h03, 1'b1);
    gc(8'h07);
    rdr(8'h04, 8'h03);
    gc(8'h06);
    rdr(8'h04, 8'h08);
    `CHECK_EQ("aborts", 2, aborts)
    for (int i = 0; i < 8; i++) begin
      m.start();
      m.wbyte(8'h08 + 8'(i), ack);
      `CHECK_EQ("hs code ack", 1'b0, ack)
      `CHECK_EQ("hs mode", 1'b1, hs_mode)
      m.start();
      m.wbyte(8'h98, ack);
      `CHECK_EQ("hs address ack", 1'b1, ack)
      m.wbyte(8'h04, ack);
      m.stop();
      cyc(8);
      `CHECK_EQ("hs mode end", 1'b0, hs_mode)
    end
    m.start();
    m.wbyte(8'h19, ack);
    m.stop();
    `CHECK_EQ("idle alert ack", 1'b0, ack)
    for (int i = 0; i < 2; i++) begin
      thermal_raise = (i == 0);
      alert_raise = 1'b1;
      cyc(1);
      alert_raise = 1'b0;
      m.start();
      m.wbyte(8'h19, ack);
      `CHECK_EQ("alert ack", 1'b1, ack)
      m.rbyte(1'b1, rd);
      m.stop();
      `CHECK_EQ("alert reply", (i == 0) ? 8'h99 : 8'h98, rd)
      `CHECK_EQ("thermal out", i == 0, thermal_limit_out)
      cyc(8);
      `CHECK_EQ("alert after", 1'b0, alert_out)
    end
    thermal_raise = 1'b0;
    // Stall the clock low in the ack slot, first armed then disarmed
    for (int i = 0; i < 2; i++) begin
      if (i == 1) wr(8'h22, 8'h00, 1'b1);
      m.start();
      for (int b = 7; b >= 0; b--) m.send_bit(adr[b], r);
      cyc(TO_CYC + 50);
      `CHECK_EQ("held line", (i == 1), sda_oe)
      m.send_bit(1'b1, r);
      m.stop();
    end
    wr(8'hFC, 8'h00, 1'b1);
    rdr(8'h22, 8'h81);
    complete_run();
  end
endmodule
